// file: verilog/fctirq_pkg.sv
// fctirq_pkg: constants shared by the fixed-cycle timer block
package fctirq_pkg;
   // ****************************************************************
   // Overview of operation
   // RULE_01 - select bits pick 4096, 64, 1, 1/60 Hz
   // RULE_02 - pin release time follows the source setting
   // RULE_03 - minute source uses timekeeping minute update
   // RULE_04 - one-second source uses its own divider
   // RULE_05 - reload count is eight bits, one to 255
   // RULE_06 - tick decrements; one-to-zero sets the flag
   // RULE_07 - run rising loads the reload count
   // RULE_08 - running count is never readable
   // RULE_09 - run cleared halts ticks and events
   // RULE_10 - software clears flag before starting single-shot
   // RULE_11 - event sets flag, drives pin if enabled
   // RULE_12 - writing flag zero clears; one is ignored
   // RULE_13 - flag sticky; run clear keeps flag and pin (code drops the repeated-mode pulse on run clear)
   // RULE_14 - with flag set, pin follows interrupt enable
   // RULE_15 - enable low at event keeps pin released
   // RULE_16 - counting starts at the run-setting write edge
   // RULE_17 - first interval may be one period short
   // RULE_18 - single-shot gives one event then stops
   // RULE_19 - single-shot pin released once flag cleared
   // RULE_20 - mode bit: zero single-shot, one repeated
   // RULE_21 - repeated mode reloads after each event
   // RULE_22 - repeated mode pin low for release time
   // RULE_23 - reload value zero never produces an event
   // ****************************************************************

   // ****************************************************************
   // clock and timing
   // ****************************************************************
   localparam int unsigned CLK_PERIOD_NS = 25;
   localparam int unsigned RTN_FAST_US = 122;
   localparam int unsigned RTN_SLOW_US = 7813;
   // longest times: round down to whole cycles
   localparam int unsigned RTN_FAST_CYC = (RTN_FAST_US * 1000) / CLK_PERIOD_NS;
   localparam int unsigned RTN_SLOW_CYC = (RTN_SLOW_US * 1000) / CLK_PERIOD_NS;
   localparam int unsigned RTN_CNT_W = 19;

   // ****************************************************************
   // oscillator divider taps (counts of 32768 Hz edges)
   // ****************************************************************
   localparam int unsigned PRE_W = 15;
   localparam logic [14:0] PRE_4096_MASK = 15'h0007;
   localparam logic [14:0] PRE_64_MASK = 15'h01FF;
   localparam logic [14:0] PRE_1_MASK = 15'h7FFF;

   // ****************************************************************
   // source select codes
   // ****************************************************************
   typedef logic [1:0] fctirq_src_t;
   localparam fctirq_src_t SRC_4096HZ = 2'h0;
   localparam fctirq_src_t SRC_64HZ = 2'h1;
   localparam fctirq_src_t SRC_1HZ = 2'h2;
   localparam fctirq_src_t SRC_1MIN = 2'h3;

   // ****************************************************************
   // register indexes (byte address = index * 4) and fields
   // ****************************************************************
   localparam logic [3:0] REG_SETUP_IDX = 4'hC;
   localparam logic [3:0] REG_RELOAD_IDX = 4'hD;
   localparam logic [3:0] REG_CTRL_IDX = 4'hE;
   localparam logic [3:0] REG_STATUS_IDX = 4'hB;
   localparam int unsigned SETUP_RUN_BIT = 7;
   localparam int unsigned SETUP_SRC_HI_BIT = 5;
   localparam int unsigned SETUP_SRC_LO_BIT = 4;
   localparam int unsigned CTRL_REPEAT_BIT = 4;
   localparam int unsigned CTRL_FLAG_BIT = 2;
   localparam int unsigned CTRL_IE_BIT = 0;
   localparam int unsigned STAT_DRIVE_BIT = 0;
   localparam int unsigned STAT_RUN_BIT = 1;
   localparam int unsigned STAT_PIN_BIT = 2;
   localparam logic [7:0] RELOAD_RST = 8'h00;
   localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;
endpackage : fctirq_pkg

// file: verilog/fctirq_tick_if.sv
// fctirq_tick_if: source select and tick between timer core and divider
interface fctirq_tick_if;
   fctirq_pkg::fctirq_src_t sel;
   logic tick;
   modport gen (input sel, output tick);
   modport user (output sel, input tick);
endinterface : fctirq_tick_if

// file: verilog/fctirq_tick_gen.sv
// fctirq_tick_gen: oscillator divider producing the countdown source ticks
module fctirq_tick_gen (
   input wire logic clk,
   input wire logic reset,
   input wire logic osc_32k,
   input wire logic minute_update,
   fctirq_tick_if.gen tk
);
   import fctirq_pkg::*;

   logic osc_s1_q;
   logic osc_s2_q;
   logic osc_s3_q;
   logic osc_rise;
   logic [PRE_W-1:0] pre_q;
   logic tick_q;

   // ****************************************************************
   // oscillator synchroniser
   // ****************************************************************
   // two flops before use, third only for the edge detect
   always_ff @(posedge clk) begin
      if (reset) begin
         osc_s1_q <= 1'b0;
         osc_s2_q <= 1'b0;
         osc_s3_q <= 1'b0;
      end else begin
         osc_s1_q <= osc_32k;
         osc_s2_q <= osc_s1_q;
         osc_s3_q <= osc_s2_q;
      end
   end
   assign osc_rise = osc_s2_q & ~osc_s3_q;

   // ****************************************************************
   // free-running divider
   // ****************************************************************
   // never restarted by the timer, so the first interval can be short
   always_ff @(posedge clk) begin
      if (reset) begin
         pre_q <= '0;
      end else if (osc_rise) begin
         pre_q <= pre_q + 15'h0001; // RULE_17
      end
   end

   // tick selection, one clk wide
   always_ff @(posedge clk) begin
      if (reset) begin
         tick_q <= 1'b0;
      end else begin
         unique case (tk.sel)
            SRC_4096HZ: tick_q <= osc_rise && ((pre_q & PRE_4096_MASK) == PRE_4096_MASK); // RULE_01
            SRC_64HZ: tick_q <= osc_rise && ((pre_q & PRE_64_MASK) == PRE_64_MASK); // RULE_01
            SRC_1HZ: tick_q <= osc_rise && (pre_q == PRE_1_MASK); // RULE_04
            SRC_1MIN: tick_q <= minute_update; // RULE_03
         endcase
      end
   end
   assign tk.tick = tick_q;
endmodule : fctirq_tick_gen

// file: verilog/fctirq_timer.sv
// fctirq_timer: fixed-cycle countdown timer with open-drain interrupt pin
module fctirq_timer #(
   parameter int unsigned RTN_FAST_CYC = fctirq_pkg::RTN_FAST_CYC,
   parameter int unsigned RTN_SLOW_CYC = fctirq_pkg::RTN_SLOW_CYC
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic osc_32k,
   input wire logic minute_update,
   input wire logic [5:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic timer_irq_n_i,
   output logic timer_irq_n_o,
   output logic timer_irq_n_oe_n
);
   import fctirq_pkg::*;

   // ****************************************************************
   // declarations
   // ****************************************************************
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_COUNT,
      ST_DONE
   } fctirq_state_t;

   fctirq_state_t state_q;
   fctirq_tick_if tk ();

   // bus slave
   logic wait_q;
   logic [31:0] rdata_q;
   logic [3:0] idx;
   logic req;
   logic wr_go;
   logic wr_lane0;
   logic wr_setup;
   logic wr_reload;
   logic wr_ctrl;

   // software visible settings
   logic timer_run_q;
   logic src_sel_hi_q;
   logic src_sel_lo_q;
   logic [7:0] reload_q;
   logic timer_repeat_select_q;
   logic timer_irq_enable_q;
   logic timer_event_flag_q;

   // countdown state
   logic [7:0] cnt_q;
   logic run_rise;
   logic run_fall;
   logic event_hit;

   // pin control
   logic pulse_q;
   logic [RTN_CNT_W-1:0] rtn_cnt_q;
   logic [RTN_CNT_W-1:0] rtn_load;
   logic drive_d;
   logic drive_q;
   logic pin_s1_q;
   logic pin_s2_q;

   // ****************************************************************
   // source tick divider
   // ****************************************************************
   assign tk.sel = {src_sel_hi_q, src_sel_lo_q}; // RULE_01

   fctirq_tick_gen u_tick_gen (
      .clk(clk),
      .reset(reset),
      .osc_32k(osc_32k),
      .minute_update(minute_update),
      .tk(tk)
   );

   // ****************************************************************
   // register bus slave
   // ****************************************************************
   // byte address, one word per register
   assign idx = avs_address[5:2];
   assign req = avs_read | avs_write;
   // a write lands on the edge where waitrequest is seen low
   assign wr_go = avs_write & ~wait_q;
   assign wr_lane0 = wr_go & avs_byteenable[0];
   assign wr_setup = wr_lane0 && (idx == REG_SETUP_IDX);
   assign wr_reload = wr_lane0 && (idx == REG_RELOAD_IDX);
   assign wr_ctrl = wr_lane0 && (idx == REG_CTRL_IDX);

   // one wait cycle per access, then a single ready cycle
   always_ff @(posedge clk) begin
      if (reset) begin
         wait_q <= 1'b1;
      end else if (!wait_q) begin
         wait_q <= 1'b1;
      end else if (req) begin
         wait_q <= 1'b0;
      end
   end
   assign avs_waitrequest = wait_q;

   // read data captured in the wait cycle, unmapped reads give zero
   always_ff @(posedge clk) begin
      if (reset) begin
         rdata_q <= RDATA_ZERO;
      end else if (avs_read && wait_q) begin
         rdata_q <= RDATA_ZERO;
         unique case (idx)
            REG_SETUP_IDX: begin
               rdata_q[SETUP_RUN_BIT] <= timer_run_q;
               rdata_q[SETUP_SRC_HI_BIT] <= src_sel_hi_q;
               rdata_q[SETUP_SRC_LO_BIT] <= src_sel_lo_q;
            end
            // the preset is returned, never the live count
            REG_RELOAD_IDX: rdata_q[7:0] <= reload_q; // RULE_08
            REG_CTRL_IDX: begin
               rdata_q[CTRL_REPEAT_BIT] <= timer_repeat_select_q;
               rdata_q[CTRL_FLAG_BIT] <= timer_event_flag_q;
               rdata_q[CTRL_IE_BIT] <= timer_irq_enable_q;
            end
            REG_STATUS_IDX: begin
               rdata_q[STAT_DRIVE_BIT] <= drive_q;
               rdata_q[STAT_RUN_BIT] <= (state_q == ST_COUNT);
               rdata_q[STAT_PIN_BIT] <= pin_s2_q;
            end
            default: rdata_q <= RDATA_ZERO;
         endcase
      end
   end
   assign avs_readdata = rdata_q;

   // ****************************************************************
   // setup register
   // ****************************************************************
   always_ff @(posedge clk) begin
      if (reset) begin
         timer_run_q <= 1'b0;
         src_sel_hi_q <= 1'b0;
         src_sel_lo_q <= 1'b0;
      end else if (wr_setup) begin
         timer_run_q <= avs_writedata[SETUP_RUN_BIT];
         src_sel_hi_q <= avs_writedata[SETUP_SRC_HI_BIT];
         src_sel_lo_q <= avs_writedata[SETUP_SRC_LO_BIT];
      end
   end

   // start and stop are taken from the write itself, same edge
   assign run_rise = wr_setup & ~timer_run_q & avs_writedata[SETUP_RUN_BIT]; // RULE_16
   assign run_fall = wr_setup & timer_run_q & ~avs_writedata[SETUP_RUN_BIT];

   // ****************************************************************
   // reload count register
   // ****************************************************************
   // any eight-bit value is stored; zero is handled by the counter
   always_ff @(posedge clk) begin
      if (reset) begin
         reload_q <= RELOAD_RST;
      end else if (wr_reload) begin
         reload_q <= avs_writedata[7:0]; // RULE_05
      end
   end

   // ****************************************************************
   // control register: mode and interrupt enable
   // ****************************************************************
   always_ff @(posedge clk) begin
      if (reset) begin
         timer_repeat_select_q <= 1'b0;
         timer_irq_enable_q <= 1'b0;
      end else if (wr_ctrl) begin
         timer_repeat_select_q <= avs_writedata[CTRL_REPEAT_BIT]; // RULE_20
         timer_irq_enable_q <= avs_writedata[CTRL_IE_BIT];
      end
   end

   // ****************************************************************
   // countdown state machine
   // ****************************************************************
   // a zero preset never reaches the one-to-zero step
   assign event_hit = (state_q == ST_COUNT) && tk.tick && (cnt_q == 8'h01); // RULE_06 RULE_23

   always_ff @(posedge clk) begin
      if (reset) begin
         state_q <= ST_IDLE;
         cnt_q <= 8'h00;
      end else if (run_rise) begin
         state_q <= ST_COUNT; // RULE_07
         cnt_q <= reload_q; // RULE_07
      end else if (run_fall) begin
         state_q <= ST_IDLE; // RULE_09
      end else begin
         unique case (state_q)
            ST_IDLE: begin
               state_q <= ST_IDLE;
            end
            ST_COUNT: begin
               if (event_hit && timer_repeat_select_q) begin
                  cnt_q <= reload_q; // RULE_21
               end else if (event_hit) begin
                  cnt_q <= 8'h00;
                  state_q <= ST_DONE; // RULE_18
               end else if (tk.tick && (cnt_q != 8'h00)) begin
                  cnt_q <= cnt_q - 8'h01; // RULE_06
               end
            end
            // single-shot finished: wait for a fresh start
            ST_DONE: begin
               state_q <= ST_DONE; // RULE_18
            end
         endcase
      end
   end

   // ****************************************************************
   // event flag
   // ****************************************************************
   // set beats clear; writing one is ignored
   always_ff @(posedge clk) begin
      if (reset) begin
         timer_event_flag_q <= 1'b0;
      end else if (event_hit) begin
         timer_event_flag_q <= 1'b1; // RULE_11
      end else if (wr_ctrl && !avs_writedata[CTRL_FLAG_BIT]) begin
         timer_event_flag_q <= 1'b0; // RULE_12
      end
   end

   // ****************************************************************
   // repeated-mode release pulse
   // ****************************************************************
   // release time follows the source at the event
   assign rtn_load = (tk.sel == SRC_4096HZ) ? RTN_CNT_W'(RTN_FAST_CYC)
                                            : RTN_CNT_W'(RTN_SLOW_CYC); // RULE_02

   always_ff @(posedge clk) begin
      if (reset) begin
         pulse_q <= 1'b0;
         rtn_cnt_q <= '0;
      end else if (event_hit && timer_repeat_select_q && timer_irq_enable_q) begin
         pulse_q <= 1'b1; // RULE_22
         rtn_cnt_q <= rtn_load; // RULE_02
      end else if (run_fall || !timer_irq_enable_q || !timer_repeat_select_q) begin
         // stop, disable or mode change drop it
         pulse_q <= 1'b0;
         rtn_cnt_q <= '0;
      end else if (pulse_q && (rtn_cnt_q <= RTN_CNT_W'(1))) begin
         pulse_q <= 1'b0; // RULE_22
         rtn_cnt_q <= '0;
      end else if (pulse_q) begin
         rtn_cnt_q <= rtn_cnt_q - RTN_CNT_W'(1);
      end
   end

   // ****************************************************************
   // interrupt pin drive
   // ****************************************************************
   // single-shot: level follows flag and enable, run bit has no say
   always_comb begin
      if (timer_repeat_select_q) begin
         drive_d = pulse_q & timer_irq_enable_q; // RULE_22
      end else begin
         drive_d = timer_event_flag_q & timer_irq_enable_q; // RULE_13 RULE_14 RULE_15 RULE_19
      end
   end

   // pin driven low while the active-low enable is low
   always_ff @(posedge clk) begin
      if (reset) begin
         drive_q <= 1'b0;
         timer_irq_n_oe_n <= 1'b1;
         timer_irq_n_o <= 1'b0;
      end else begin
         drive_q <= drive_d;
         timer_irq_n_oe_n <= ~drive_d; // RULE_11
         timer_irq_n_o <= 1'b0;
      end
   end

   // ****************************************************************
   // pin level readback
   // ****************************************************************
   // the wired line is outside our clock, so it is synchronised
   always_ff @(posedge clk) begin
      if (reset) begin
         pin_s1_q <= 1'b1;
         pin_s2_q <= 1'b1;
      end else begin
         pin_s1_q <= timer_irq_n_i;
         pin_s2_q <= pin_s1_q;
      end
   end
endmodule : fctirq_timer

// file: verif/fctirq_timer_monitor.sv
// fctirq_timer_monitor: port assertions for the timer
module fctirq_timer_monitor #(
   parameter int unsigned RTN_FAST_CYC = 20,
   parameter int unsigned RTN_SLOW_CYC = 50
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic [5:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire logic timer_irq_n_o,
   input wire logic timer_irq_n_oe_n
);
   import fctirq_pkg::*;
   logic wr_acc, rd_acc, ctl_acc, ie_q, rep_q;
   logic [3:0] idx;
   logic [7:0] wd, reload_q;
   logic [1:0] sel_q;
   logic [18:0] low_q;
   int unsigned lim;
   // ************
   // shadow state
   // ************
   // transfers count where waitrequest is low
   assign idx = avs_address[5:2];
   assign wd = avs_writedata[7:0];
   assign wr_acc = avs_write && !avs_waitrequest;
   assign rd_acc = avs_read && !avs_waitrequest;
   assign ctl_acc = wr_acc && avs_byteenable[0] && idx == REG_CTRL_IDX;
   assign lim = (sel_q == SRC_4096HZ) ? RTN_FAST_CYC : RTN_SLOW_CYC;
   // software fields, lane 0 only
   always_ff @(posedge clk) begin
      if (reset) begin
         reload_q <= RELOAD_RST;
         sel_q <= SRC_4096HZ;
         ie_q <= 1'b0;
         rep_q <= 1'b0;
      end else if (wr_acc && avs_byteenable[0]) begin
         if (idx == REG_RELOAD_IDX) begin
            reload_q <= wd;
         end
         if (idx == REG_SETUP_IDX) begin
            sel_q <= wd[5:4];
         end
         if (ctl_acc) begin
            ie_q <= wd[CTRL_IE_BIT];
            rep_q <= wd[CTRL_REPEAT_BIT];
         end
      end
   end
   // cycles the pin has been low
   always_ff @(posedge clk) begin
      if (reset || timer_irq_n_oe_n) begin
         low_q <= 19'h0_0000;
      end else begin
         low_q <= low_q + 19'h0_0001;
      end
   end
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);
   property p_od_low;
      1'b1 |-> timer_irq_n_o == 1'b0;
   endproperty
   a_od_low: assert property (p_od_low) else $error("pin drive value not low");
   property p_ie_release;
      ctl_acc && !wd[CTRL_IE_BIT] |=> ##1 timer_irq_n_oe_n [*2];
   endproperty
   a_ie_release: assert property (p_ie_release) else $error("pin low with enable off");
   property p_flag_clr;
      ctl_acc && !wd[CTRL_FLAG_BIT] && !wd[CTRL_REPEAT_BIT]
         |=> ##1 timer_irq_n_oe_n;
   endproperty
   a_flag_clr: assert property (p_flag_clr) else $error("flag clear kept pin low");
   property p_run_stop;
      wr_acc && idx == REG_SETUP_IDX && avs_byteenable[0] && !wd[SETUP_RUN_BIT] && rep_q
         |=> ##1 timer_irq_n_oe_n;
   endproperty
   a_run_stop: assert property (p_run_stop) else $error("stop kept repeated pin low");
   property p_low_bound;
      rep_q && !timer_irq_n_oe_n |-> low_q < lim;
   endproperty
   a_low_bound: assert property (p_low_bound) else $error("repeated pulse too long");
   property p_fell_ie;
      $fell(timer_irq_n_oe_n) |-> $past(ie_q);
   endproperty
   a_fell_ie: assert property (p_fell_ie) else $error("pin driven with enable off");
   property p_drive_single;
      !rep_q && !timer_irq_n_oe_n && !ctl_acc && !$past(ctl_acc) |=> !timer_irq_n_oe_n;
   endproperty
   a_drive_single: assert property (p_drive_single) else $error("pin let go alone");
   property p_reload_rd;
      rd_acc && idx == REG_RELOAD_IDX |-> avs_readdata == {24'h00_0000, reload_q};
   endproperty
   a_reload_rd: assert property (p_reload_rd) else $error("reload readback wrong");
   property p_sel_rd;
      rd_acc && idx == REG_SETUP_IDX |-> avs_readdata[5:4] == sel_q;
   endproperty
   a_sel_rd: assert property (p_sel_rd) else $error("source select readback wrong");
   property p_hi_zero;
      rd_acc |-> avs_readdata[31:8] == 24'h00_0000;
   endproperty
   a_hi_zero: assert property (p_hi_zero) else $error("upper read bits set");
   c_rep: cover property ($fell(timer_irq_n_oe_n) && rep_q);
   c_single: cover property ($fell(timer_irq_n_oe_n) && !rep_q);
   c_read: cover property (rd_acc && idx == REG_RELOAD_IDX);
endmodule : fctirq_timer_monitor

bind fctirq_timer fctirq_timer_monitor #(
   .RTN_FAST_CYC(RTN_FAST_CYC),
   .RTN_SLOW_CYC(RTN_SLOW_CYC)
) u_mon (
   .clk(clk),
   .reset(reset),
   .avs_address(avs_address),
   .avs_read(avs_read),
   .avs_write(avs_write),
   .avs_writedata(avs_writedata),
   .avs_byteenable(avs_byteenable),
   .avs_readdata(avs_readdata),
   .avs_waitrequest(avs_waitrequest),
   .timer_irq_n_o(timer_irq_n_o),
   .timer_irq_n_oe_n(timer_irq_n_oe_n)
);

// file: verif/fctirq_pin_model.sv
// fctirq_pin_model: crystal source and pulled-up open-drain interrupt line
module fctirq_pin_model #(
   parameter real OSC_HALF_NS = 15258.789
) (
   output logic osc_32k,
   input wire logic timer_irq_n_o,
   input wire logic timer_irq_n_oe_n,
   output wire logic line_level
);
   timeunit 1ns;
   timeprecision 1ps;
   // 32768 Hz, phase unrelated to clk
   initial osc_32k = 1'b0;
   always #(OSC_HALF_NS) osc_32k = ~osc_32k;
   // pull-up when released
   assign line_level = timer_irq_n_oe_n ? 1'b1 : timer_irq_n_o;
endmodule : fctirq_pin_model

// file: verif/fctirq_timer_bench.sv
// fctirq_timer_bench: self-checking timer bench
module fctirq_timer_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import fctirq_pkg::*;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic minute_update = 1'b0;
   logic [5:0] avs_address = 6'h00;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0000_0000;
   logic [3:0] avs_byteenable = 4'h1;
   logic [31:0] avs_readdata;
   logic avs_waitrequest, osc_32k, pin, irq_o, irq_oe_n;
   logic [7:0] rdat;
   int errors = 0;
   int samples_checked = 0;
   int n, w;
   // 40 MHz
   always #12.5 clk = ~clk;
   fctirq_timer #(.RTN_FAST_CYC(20), .RTN_SLOW_CYC(50)) dut (.clk(clk), .reset(reset),
      .osc_32k(osc_32k), .minute_update(minute_update), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .timer_irq_n_i(pin), .timer_irq_n_o(irq_o),
      .timer_irq_n_oe_n(irq_oe_n));
   fctirq_pin_model u_pin (.osc_32k(osc_32k), .timer_irq_n_o(irq_o),
      .timer_irq_n_oe_n(irq_oe_n), .line_level(pin));
   // ************
   // shared tasks
   // ************
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : end_of_test
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string m);
      samples_checked++;
      if (seen !== exp) begin
         errors++;
         $display("[FAIL] %0t %s", $time, m);
      end
   endtask : chk
   // held until waitrequest low; a hang ends the run
   task automatic bus(input logic wr, input logic [3:0] i, input logic [7:0] d,
         input logic [3:0] be);
      int k;
      k = 0;
      @(posedge clk);
      avs_read <= ~wr;
      avs_write <= wr;
      avs_address <= {i, 2'b00};
      avs_writedata <= {24'h00_0000, d};
      avs_byteenable <= be;
      do begin
         @(posedge clk);
         k++;
      end while (avs_waitrequest !== 1'b0 && k < 20);
      if (avs_waitrequest !== 1'b0) begin
         errors++;
         end_of_test();
      end
      rdat = avs_readdata[7:0];
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask : bus
   task automatic wr(input logic [3:0] i, input logic [7:0] d);
      bus(1'b1, i, d, 4'h1);
   endtask : wr
   task automatic rd(input logic [3:0] i, input logic [7:0] e, input string m);
      bus(1'b0, i, 8'h00, 4'h1);
      chk({24'h00_0000, rdat}, {24'h00_0000, e}, m);
   endtask : rd
   task automatic chk_pin(input logic l);
      repeat (2) @(posedge clk);
      chk({31'h0, pin}, {31'h0, l}, "pin level");
   endtask : chk_pin
   task automatic chk_flag(input logic l);
      bus(1'b0, REG_CTRL_IDX, 8'h00, 4'h1);
      chk({31'h0, rdat[CTRL_FLAG_BIT]}, {31'h0, l}, "event flag");
   endtask : chk_flag
   task automatic chk_in(input int v, input int lo, input int hi, input string m);
      chk({31'h0, v >= lo && v <= hi}, 32'h0000_0001, m);
   endtask : chk_in
   task automatic start(input logic [7:0] c, input logic [7:0] r);
      wr(REG_CTRL_IDX, c);
      wr(REG_RELOAD_IDX, r);
      wr(REG_SETUP_IDX, 8'hB0);
   endtask : start
   // minute pulses, each with room to settle
   task automatic tick_min(input int c);
      repeat (c) begin
         @(posedge clk);
         minute_update <= 1'b1;
         @(posedge clk);
         minute_update <= 1'b0;
         repeat (6) @(posedge clk);
      end
   endtask : tick_min
   task automatic wait_pin(input logic l, input int lim);
      n = 0;
      while (pin !== l && n < lim) begin
         @(posedge clk);
         n++;
      end
      if (pin !== l) begin
         errors++;
         end_of_test();
      end
   endtask : wait_pin
   task automatic low_len();
      w = 0;
      while (pin === 1'b0 && w < 1000) begin
         @(posedge clk);
         w++;
      end
   endtask : low_len
   // *********
   // scenarios
   // *********
   task automatic t_regs();
      rd(REG_SETUP_IDX, 8'h00, "setup reset");
      rd(REG_RELOAD_IDX, RELOAD_RST, "reload reset");
      rd(REG_CTRL_IDX, 8'h00, "ctrl reset");
      rd(REG_STATUS_IDX, 8'h04, "status reset");
      wr(REG_RELOAD_IDX, 8'hFF);
      bus(1'b1, REG_RELOAD_IDX, 8'h55, 4'h0);
      rd(REG_RELOAD_IDX, 8'hFF, "reload max");
      wr(4'h0, 8'hA5);
      rd(4'h0, 8'h00, "unmapped");
      for (int s = 0; s < 4; s++) begin
         wr(REG_SETUP_IDX, {2'b00, 2'(s), 4'h0});
         rd(REG_SETUP_IDX, {2'b00, 2'(s), 4'h0}, "source select");
      end
   endtask : t_regs
   task automatic t_single();
      start(8'h01, 8'h03);
      tick_min(2);
      rd(REG_RELOAD_IDX, 8'h03, "reload while counting");
      chk_flag(1'b0);
      tick_min(1);
      chk_flag(1'b1);
      chk_pin(1'b0);
      wr(REG_CTRL_IDX, 8'h04);
      chk_pin(1'b1);
      wr(REG_CTRL_IDX, 8'h05);
      chk_pin(1'b0);
      wr(REG_SETUP_IDX, 8'h30);
      chk_pin(1'b0);
      chk_flag(1'b1);
      wr(REG_CTRL_IDX, 8'h01);
      chk_pin(1'b1);
      wr(REG_SETUP_IDX, 8'hB0);
      tick_min(3);
      chk_flag(1'b1);
      wr(REG_CTRL_IDX, 8'h01);
      tick_min(6);
      chk_flag(1'b0);
      chk_pin(1'b1);
      wr(REG_SETUP_IDX, 8'h30);
   endtask : t_single
   task automatic t_ie_off_stop();
      start(8'h00, 8'h01);
      tick_min(1);
      chk_flag(1'b1);
      chk_pin(1'b1);
      wr(REG_SETUP_IDX, 8'h30);
      start(8'h01, 8'h02);
      tick_min(1);
      wr(REG_SETUP_IDX, 8'h30);
      tick_min(3);
      chk_flag(1'b0);
      wr(REG_SETUP_IDX, 8'hB0);
      tick_min(1);
      chk_flag(1'b0);
      tick_min(1);
      chk_flag(1'b1);
      wr(REG_SETUP_IDX, 8'h30);
      start(8'h01, 8'h00);
      tick_min(4);
      chk_flag(1'b0);
      wr(REG_SETUP_IDX, 8'h30);
   endtask : t_ie_off_stop
   task automatic t_repeat();
      start(8'h11, 8'h02);
      tick_min(1);
      @(posedge clk);
      minute_update <= 1'b1;
      @(posedge clk);
      minute_update <= 1'b0;
      wait_pin(1'b0, 10);
      low_len();
      chk_in(w, 49, 51, "slow release width");
      tick_min(1);
      chk_pin(1'b1);
      tick_min(1);
      chk_pin(1'b0);
      wr(REG_CTRL_IDX, 8'h11);
      chk_pin(1'b0);
      wr(REG_SETUP_IDX, 8'h30);
      chk_pin(1'b1);
   endtask : t_repeat
   task automatic t_fast();
      wr(REG_SETUP_IDX, 8'h80);
      wait_pin(1'b0, 20000);
      chk_in(n, 9760, 19545, "first interval");
      low_len();
      chk_in(w, 19, 21, "fast release width");
      wait_pin(1'b0, 20000);
      chk_in(n + w, 19525, 19540, "repeat interval");
      wr(REG_SETUP_IDX, 8'h00);
      wr(REG_CTRL_IDX, 8'h00);
   endtask : t_fast
   // reset, then each scenario
   initial begin
      repeat (5) @(posedge clk);
      reset <= 1'b0;
      t_regs();
      t_single();
      t_ie_off_stop();
      t_repeat();
      t_fast();
      end_of_test();
   end
endmodule : fctirq_timer_bench
